// ---- dcc_pkg.sv ----
// package: constants and register map for the completion, chain and region interrupt block
//
// Overview of operation
// - a finished transfer request may raise an event on another channel, parameters untouched
// - final chaining alone triggers once, after the last request submits or completes
// - intermediate chaining alone triggers after each request except the last
// - both chaining enables trigger after every transfer request
// - requests per set: second times third count, or third count when AB-synchronized
// - completion interrupts apart from errors; one completion interrupt per shadow region
// - codes 0..31 set pending low bit, 32..63 set pending high bit code-32
// - a returned completion code sets its pending bit; returned only when irq enabled
// - any code on any channel; shared codes set the same pending bit
// - final irq enable alone reports only after the last request
// - intermediate irq enable alone reports each request except the last
// - both irq enables report after every transfer request
// - region irq is OR over 64 codes of pending, enable and region mask
// - writing one to a pending clear bit clears it; zero does nothing; a code returned in the same cycle keeps its bit set
// - region irq pulses when enabled pending goes from none to some
// - the reevaluate bit re-pulses the region irq while enabled pending bits remain
package dcc_pkg;

	localparam int unsigned NUM_CODES   = 64;
	localparam int unsigned CODE_W      = 6;
	localparam int unsigned NUM_REGIONS = 8;
	localparam int unsigned DIM_W       = 16;
	localparam int unsigned TOTAL_W     = 32;
	localparam int unsigned ADDR_W      = 8;

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_PENDING_LOW       = 8'h00;
	localparam logic [7:0] OFS_PENDING_HIGH      = 8'h04;
	localparam logic [7:0] OFS_PENDING_CLEAR_LOW = 8'h08;
	localparam logic [7:0] OFS_PENDING_CLEAR_HI  = 8'h0C;
	localparam logic [7:0] OFS_IRQ_ENABLE_LOW    = 8'h10;
	localparam logic [7:0] OFS_IRQ_ENABLE_HIGH   = 8'h14;
	localparam logic [7:0] OFS_IRQ_REEVALUATE    = 8'h18;
	localparam logic [7:0] OFS_REGION_MASK_BASE  = 8'h40;
	localparam logic [7:0] OFS_REGION_MASK_END   = 8'h80;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int unsigned REEVALUATE_BIT   = 0;
	localparam int unsigned MASK_REGION_LSB  = 3;
	localparam int unsigned MASK_HIGH_BIT    = 2;
	localparam logic [31:0] RST_WORD         = 32'h0000_0000;
	localparam logic [63:0] RST_PENDING      = 64'h0000_0000_0000_0000;
	localparam logic [63:0] RST_IRQ_ENABLE   = 64'h0000_0000_0000_0000;
	localparam logic [63:0] RST_REGION_MASK  = 64'h0000_0000_0000_0000;

	typedef enum logic {
		DCC_EV_SUBMIT   = 1'b0,
		DCC_EV_COMPLETE = 1'b1
	} dcc_event_kind_type;

endpackage : dcc_pkg

// ---- dcc_code_decode.sv ----
// module: one-hot decoder of a completion code, gated by a strobe
`timescale 1ns/10ps
`default_nettype none
module dcc_code_decode #(
	parameter int unsigned CW = 6
) (
	input  wire logic [CW-1:0]      code,
	input  wire logic               strobe,
	output logic      [(1<<CW)-1:0] onehot
);
	always_comb begin
		onehot       = '0;
		onehot[code] = strobe;
	end
endmodule : dcc_code_decode
`default_nettype wire

// ---- dcc_region_irq.sv ----
// module: completion interrupt pulse for one shadow region
`timescale 1ns/10ps
`default_nettype none
module dcc_region_irq
	import dcc_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [NUM_CODES-1:0] pending,
	input  wire logic [NUM_CODES-1:0] enable,
	input  wire logic [NUM_CODES-1:0] region_mask,
	input  wire logic                 reevaluate,
	output logic                      irq_ff
);
	logic any_now;
	logic any_prev_ff;
	logic nxt_any_prev;
	logic nxt_irq;

	always_comb begin
		any_now      = |(pending & enable & region_mask);
		nxt_any_prev = any_now;
		nxt_irq      = (any_now & ~any_prev_ff) | (reevaluate & any_now);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			any_prev_ff <= 1'b0;
			irq_ff      <= 1'b0;
		end else begin
			any_prev_ff <= nxt_any_prev;
			irq_ff      <= nxt_irq;
		end
	end

	a_irq_rise_only: assert property (@(posedge clk) disable iff (rst)
		(any_now && any_prev_ff && !reevaluate) |=> !irq_ff)
		else $error("region irq pulsed while enabled pending stayed set");
	a_irq_on_rise: assert property (@(posedge clk) disable iff (rst)
		(any_now && !any_prev_ff) |=> irq_ff)
		else $error("region irq missed a rise of enabled pending");
	c_irq_reeval: cover property (@(posedge clk) disable iff (rst) reevaluate && any_prev_ff ##1 irq_ff);
endmodule : dcc_region_irq
`default_nettype wire

// ---- dcc_top.sv ----
// module: completion code handling, channel chaining and region completion interrupts with APB registers
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module dcc_top
	import dcc_pkg::*;
(
	input  wire logic                          clk,
	input  wire logic                          rst,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [dcc_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata_ff,
	output logic                               pready_ff,
	output logic                               pslverr_ff,
	// transfer request events from sequencing / transfer controllers
	input  wire logic                          req_valid,
	input  wire dcc_pkg::dcc_event_kind_type   req_kind,
	input  wire logic [dcc_pkg::CODE_W-1:0]    req_channel,
	input  wire logic                          req_first,
	input  wire logic [dcc_pkg::CODE_W-1:0]    completion_code,
	input  wire logic                          early_completion,
	input  wire logic                          final_chain_enable,
	input  wire logic                          intermediate_chain_enable,
	input  wire logic                          final_done_irq_enable,
	input  wire logic                          intermediate_done_irq_enable,
	input  wire logic                          ab_sync,
	input  wire logic [dcc_pkg::DIM_W-1:0]     second_dim_count,
	input  wire logic [dcc_pkg::DIM_W-1:0]     third_dim_count,
	// outputs
	output logic      [dcc_pkg::NUM_CODES-1:0] chain_event_ff,
	output logic      [dcc_pkg::NUM_REGIONS-1:0] region_done_irq
);
	import dcc_pkg::*;

	// ------------------------------------------------------------
	// request counting per channel
	// ------------------------------------------------------------
	logic [TOTAL_W-1:0] remain_mem [NUM_CODES];
	logic [TOTAL_W-1:0] set_total;
	logic [TOTAL_W-1:0] remaining;
	logic [TOTAL_W-1:0] nxt_remain;
	logic               counted;
	logic               is_last;
	logic               chain_fire;
	logic               irq_fire;

	always_comb begin
		// requests per parameter set
		if (ab_sync) begin
			set_total = TOTAL_W'(third_dim_count);
		end else begin
			set_total = TOTAL_W'(second_dim_count) * TOTAL_W'(third_dim_count);
		end
		// only the event matching the completion mode counts
		counted    = req_valid & ((req_kind == DCC_EV_SUBMIT) == early_completion);
		remaining  = req_first ? set_total : remain_mem[req_channel];
		// a zero count is treated as a single request to avoid wrapping
		is_last    = (remaining <= TOTAL_W'(1));
		nxt_remain = is_last ? '0 : remaining - TOTAL_W'(1);
		chain_fire = counted & ((is_last & final_chain_enable)
			| (~is_last & intermediate_chain_enable));
		irq_fire   = counted & ((is_last & final_done_irq_enable)
			| (~is_last & intermediate_done_irq_enable));
	end

	// counter memory has no reset: the first request of a set always reloads it
	always_ff @(posedge clk) begin
		if (counted) begin
			remain_mem[req_channel] <= nxt_remain;
		end
	end

	// ------------------------------------------------------------
	// chain events and pending set
	// ------------------------------------------------------------
	logic [NUM_CODES-1:0] chain_onehot;
	logic [NUM_CODES-1:0] pend_set;

	// only an event is produced; parameter sets are never written here
	dcc_code_decode #(.CW(CODE_W)) u_chain_dec (
		.code   (completion_code),
		.strobe (chain_fire),
		.onehot (chain_onehot)
	);

	// any code from any channel, no tie to the channel number
	dcc_code_decode #(.CW(CODE_W)) u_pend_dec (
		.code   (completion_code),
		.strobe (irq_fire),
		.onehot (pend_set)
	);

	// ------------------------------------------------------------
	// apb register file
	// ------------------------------------------------------------
	logic [NUM_CODES-1:0] pending_ff;
	logic [NUM_CODES-1:0] irq_enable_ff;
	logic [NUM_CODES-1:0] region_mask_ff [NUM_REGIONS];
	logic                 reevaluate_ff;
	logic [NUM_CODES-1:0] nxt_pending;
	logic [NUM_CODES-1:0] nxt_irq_enable;
	logic [NUM_CODES-1:0] nxt_region_mask [NUM_REGIONS];
	logic                 nxt_reevaluate;
	logic [NUM_CODES-1:0] nxt_chain_event;
	logic [NUM_CODES-1:0] clr_mask;
	logic [31:0]          nxt_prdata;
	logic                 nxt_pready;
	logic                 nxt_pslverr;
	logic                 setup;
	logic                 wr_en;
	logic                 in_mask;
	logic [2:0]           mask_idx;
	logic                 mask_hi;

	always_comb begin
		setup          = psel & ~penable;
		wr_en          = psel & penable & pready_ff & pwrite;
		in_mask        = (paddr >= OFS_REGION_MASK_BASE) && (paddr < OFS_REGION_MASK_END);
		mask_idx       = paddr[MASK_REGION_LSB +: 3];
		mask_hi        = paddr[MASK_HIGH_BIT];
		clr_mask       = '0;
		nxt_irq_enable = irq_enable_ff;
		nxt_reevaluate = 1'b0;
		nxt_region_mask = region_mask_ff;
		// zero-wait slave: ready rises the cycle after setup and drops after access
		nxt_pready     = setup;
		nxt_pslverr    = 1'b0;
		nxt_prdata     = prdata_ff;
		if (setup) begin
			nxt_prdata = RST_WORD;
			if (paddr == OFS_PENDING_LOW) begin
				nxt_prdata = pending_ff[31:0];
			end else if (paddr == OFS_PENDING_HIGH) begin
				nxt_prdata = pending_ff[63:32];
			end else if (paddr == OFS_IRQ_ENABLE_LOW) begin
				nxt_prdata = irq_enable_ff[31:0];
			end else if (paddr == OFS_IRQ_ENABLE_HIGH) begin
				nxt_prdata = irq_enable_ff[63:32];
			end else if (paddr == OFS_PENDING_CLEAR_LOW || paddr == OFS_PENDING_CLEAR_HI
				|| paddr == OFS_IRQ_REEVALUATE) begin
				nxt_prdata = RST_WORD;
			end else if (in_mask && paddr[1:0] == 2'h0) begin
				nxt_prdata = mask_hi ? region_mask_ff[mask_idx][63:32] : region_mask_ff[mask_idx][31:0];
			end else begin
				nxt_pslverr = 1'b1;
			end
		end
		if (wr_en && !pslverr_ff) begin
			if (paddr == OFS_PENDING_CLEAR_LOW) begin
				clr_mask[31:0] = pwdata;
			end else if (paddr == OFS_PENDING_CLEAR_HI) begin
				clr_mask[63:32] = pwdata;
			end else if (paddr == OFS_IRQ_ENABLE_LOW) begin
				nxt_irq_enable[31:0] = pwdata;
			end else if (paddr == OFS_IRQ_ENABLE_HIGH) begin
				nxt_irq_enable[63:32] = pwdata;
			end else if (paddr == OFS_IRQ_REEVALUATE) begin
				nxt_reevaluate = pwdata[REEVALUATE_BIT];
			end else if (in_mask) begin
				if (mask_hi) begin
					nxt_region_mask[mask_idx][63:32] = pwdata;
				end else begin
					nxt_region_mask[mask_idx][31:0] = pwdata;
				end
			end
		end
		// a completion arriving with its clear is kept: set wins
		nxt_pending     = (pending_ff & ~clr_mask) | pend_set;
		nxt_chain_event = chain_onehot;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pending_ff     <= RST_PENDING;
			irq_enable_ff  <= RST_IRQ_ENABLE;
			reevaluate_ff  <= 1'b0;
			chain_event_ff <= '0;
			prdata_ff      <= RST_WORD;
			pready_ff      <= 1'b0;
			pslverr_ff     <= 1'b0;
			for (int r = 0; r < NUM_REGIONS; r++) begin
				region_mask_ff[r] <= RST_REGION_MASK;
			end
		end else begin
			pending_ff     <= nxt_pending;
			irq_enable_ff  <= nxt_irq_enable;
			reevaluate_ff  <= nxt_reevaluate;
			chain_event_ff <= nxt_chain_event;
			prdata_ff      <= nxt_prdata;
			pready_ff      <= nxt_pready;
			pslverr_ff     <= nxt_pslverr;
			region_mask_ff <= nxt_region_mask;
		end
	end

	// ------------------------------------------------------------
	// one completion interrupt per shadow region
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_REGIONS; g++) begin : g_region
			dcc_region_irq u_irq (
				.clk         (clk),
				.rst         (rst),
				.pending     (pending_ff),
				.enable      (irq_enable_ff),
				.region_mask (region_mask_ff[g]),
				.reevaluate  (reevaluate_ff),
				.irq_ff      (region_done_irq[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_pend_set_code: assert property (@(posedge clk) disable iff (rst)
		irq_fire |=> pending_ff[$past(completion_code)])
		else $error("completion code did not set its pending bit");
	a_pend_clear_one: assert property (@(posedge clk) disable iff (rst)
		(wr_en && !pslverr_ff && paddr == OFS_PENDING_CLEAR_LOW && pwdata[0] && !pend_set[0]) |=> !pending_ff[0])
		else $error("pending clear did not clear bit 0");
	a_pend_hold: assert property (@(posedge clk) disable iff (rst)
		(pending_ff[5] && !clr_mask[5]) |=> pending_ff[5])
		else $error("pending bit dropped without a clear");
	a_chain_last_only: assert property (@(posedge clk) disable iff (rst)
		(counted && !intermediate_chain_enable && !is_last) |=> chain_event_ff == '0)
		else $error("final-only chaining fired on an intermediate request");
	a_chain_onehot: assert property (@(posedge clk) disable iff (rst)
		chain_fire |=> chain_event_ff == (64'h1 << $past(completion_code)))
		else $error("chain event missing on the target channel");
	a_irq_inter_only: assert property (@(posedge clk) disable iff (rst)
		(counted && is_last && !final_done_irq_enable) |-> !irq_fire)
		else $error("intermediate-only irq reported the last request");
	a_count_ab: assert property (@(posedge clk) disable iff (rst)
		(counted && req_first && ab_sync) |-> remaining == TOTAL_W'(third_dim_count))
		else $error("AB-synchronized set size wrong");
	a_apb_ready: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable) |=> pready_ff ##1 !pready_ff)
		else $error("apb ready not a single cycle after setup");
	a_both_every: assert property (@(posedge clk) disable iff (rst)
		(counted && final_done_irq_enable && intermediate_done_irq_enable) |-> irq_fire)
		else $error("both irq enables did not report a request");

	// ------------------------------------------------------------
	// request counting and chain checks
	// ------------------------------------------------------------
	// a refused event kind must leave both the chain and the pending bits alone
	a_kind_refused: assert property (@(posedge clk) disable iff (rst)
		(req_valid && ((req_kind == DCC_EV_SUBMIT) != early_completion)) |-> !chain_fire && !irq_fire)
		else $error("event of the wrong completion mode was counted");
	a_chain_inter_only: assert property (@(posedge clk) disable iff (rst)
		(counted && is_last && !final_chain_enable) |=> chain_event_ff == '0)
		else $error("intermediate-only chaining fired on the last request");
	a_chain_every: assert property (@(posedge clk) disable iff (rst)
		(counted && final_chain_enable && intermediate_chain_enable) |-> chain_fire)
		else $error("both chaining enables did not trigger a request");
	a_count_a: assert property (@(posedge clk) disable iff (rst)
		(counted && req_first && !ab_sync) |-> remaining == TOTAL_W'(second_dim_count) * TOTAL_W'(third_dim_count))
		else $error("A-synchronized set size wrong");

	// ------------------------------------------------------------
	// pending bit checks
	// ------------------------------------------------------------
	a_final_irq_last: assert property (@(posedge clk) disable iff (rst)
		(counted && final_done_irq_enable && !intermediate_done_irq_enable) |-> irq_fire == is_last)
		else $error("final-only irq reported at the wrong request");
	a_inter_irq_each: assert property (@(posedge clk) disable iff (rst)
		(counted && !is_last && intermediate_done_irq_enable) |-> irq_fire)
		else $error("intermediate irq missed a request");
	// pending bits may move only through a returned code or a clear
	a_pend_quiet: assert property (@(posedge clk) disable iff (rst)
		(!irq_fire && clr_mask == '0) |=> pending_ff == $past(pending_ff))
		else $error("pending bits changed without a completion or a clear");
	a_clear_high: assert property (@(posedge clk) disable iff (rst)
		(wr_en && !pslverr_ff && paddr == OFS_PENDING_CLEAR_HI && !irq_fire)
		|=> pending_ff == ($past(pending_ff) & ~{$past(pwdata), 32'h0000_0000}))
		else $error("high pending clear touched the wrong bits");

	// ------------------------------------------------------------
	// bus and region interrupt checks
	// ------------------------------------------------------------
	// the error flag is decoded at setup only, so it can never outlive ready
	a_err_with_ready: assert property (@(posedge clk) disable iff (rst)
		pslverr_ff |-> pready_ff)
		else $error("apb error flag without ready");
	a_ready_pulse: assert property (@(posedge clk) disable iff (rst)
		pready_ff |=> !pready_ff)
		else $error("apb ready stood longer than one cycle");
	a_enable_write: assert property (@(posedge clk) disable iff (rst)
		(wr_en && !pslverr_ff && paddr == OFS_IRQ_ENABLE_LOW) |=> irq_enable_ff[31:0] == $past(pwdata))
		else $error("irq enable low write did not land");
	a_reeval_pulse: assert property (@(posedge clk) disable iff (rst)
		(reevaluate_ff && |(pending_ff & irq_enable_ff & region_mask_ff[0])) |=> region_done_irq[0])
		else $error("reevaluate did not re-pulse region 0");
	a_region_quiet: assert property (@(posedge clk) disable iff (rst)
		!(|(pending_ff & irq_enable_ff & region_mask_ff[2])) |=> !region_done_irq[2])
		else $error("region 2 pulsed with nothing enabled and pending");

	c_chain_fire: cover property (@(posedge clk) disable iff (rst) chain_fire && !is_last);
	c_pend_clear: cover property (@(posedge clk) disable iff (rst) (|clr_mask) && (|pend_set));
	c_region_irq: cover property (@(posedge clk) disable iff (rst) |region_done_irq);
endmodule : dcc_top
`default_nettype wire

// ---- dcc_irq_host.sv ----
// partner model: host side that counts completion interrupt pulses per region
`timescale 1ns/10ps
`default_nettype none
module dcc_irq_host
	import dcc_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   rst,
	input wire logic [NUM_REGIONS-1:0] region_done_irq
);
	int irq_cnt [NUM_REGIONS];

	// each region line is a separate input, counted once for every clock cycle it is high
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			foreach (irq_cnt[r]) irq_cnt[r] = 0;
		end else begin
			foreach (irq_cnt[r]) if (region_done_irq[r] === 1'b1) irq_cnt[r]++;
		end
	end
endmodule : dcc_irq_host
`default_nettype wire

// ---- dma_completion_chain_irq_test.sv ----
// testbench: chaining, pending bits and region interrupts of the completion block
`timescale 1ns/10ps
`default_nettype none
module dma_completion_chain_irq_test;
	import dcc_pkg::*;
	logic                   clk, rst, psel, penable, pwrite, pready_ff, pslverr_ff;
	logic [ADDR_W-1:0]      paddr;
	logic [31:0]            pwdata, prdata_ff;
	logic                   req_valid, req_first, early, fin_ch, int_ch, fin_irq, int_irq, ab_sync;
	dcc_event_kind_type     req_kind;
	logic [CODE_W-1:0]      req_channel, code;
	logic [DIM_W-1:0]       cnt2, cnt3;
	logic [NUM_CODES-1:0]   chain_event_ff;
	logic [NUM_REGIONS-1:0] region_done_irq;
	logic [63:0]            exp_pend, en_m;
	logic [63:0]            mask_m [NUM_REGIONS];
	int                     failures, n_compared, cyc, chain_cnt, exp_chain, seed;
	int                     exp_irq [NUM_REGIONS];

	dcc_top uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
		.req_valid(req_valid), .req_kind(req_kind), .req_channel(req_channel), .req_first(req_first),
		.completion_code(code), .early_completion(early), .final_chain_enable(fin_ch),
		.intermediate_chain_enable(int_ch), .final_done_irq_enable(fin_irq),
		.intermediate_done_irq_enable(int_irq), .ab_sync(ab_sync), .second_dim_count(cnt2),
		.third_dim_count(cnt3), .chain_event_ff(chain_event_ff), .region_done_irq(region_done_irq));
	dcc_irq_host host (.clk(clk), .rst(rst), .region_done_irq(region_done_irq));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// --------------------------------
	// checking helpers
	// --------------------------------
	task automatic stop_test;
		$display("failures=%0d n_compared=%0d", failures, n_compared);
		if (failures == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			failures++;
			stop_test();
		end
	end

	// a chain pulse on any other bit than the programmed code is a mismatch
	always @(posedge clk) begin
		if (rst === 1'b0 && chain_event_ff !== '0) begin
			if (chain_event_ff === (64'h1 << code)) begin
				chain_cnt++;
			end else begin
				failures++;
				$display("Error at %0t: stray chain event %h", $time, chain_event_ff);
			end
		end
	end

	// --------------------------------
	// bus and event drivers
	// --------------------------------
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd, input logic [31:0] rd,
			input logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready_ff !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			$display("Error at %0t: apb ready never came", $time);
		end
		chk(pslverr_ff, err, "slave error");
		if (!wr) chk(prdata_ff, rd, "read data");
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic req_ev(input dcc_event_kind_type k, input logic first);
		@(posedge clk);
		req_valid <= 1'b1;
		req_kind <= k;
		req_first <= first;
		@(posedge clk);
		req_valid <= 1'b0;
	endtask : req_ev

	// model: a pending bit rising into an enabled, masked set that had none pending pulses that region once
	function automatic void mset(input int b);
		logic [63:0] nw;
		nw = exp_pend | (64'h1 << b);
		for (int r = 0; r < NUM_REGIONS; r++) begin
			if ((exp_pend & en_m & mask_m[r]) == 0 && (nw & en_m & mask_m[r]) != 0) exp_irq[r]++;
		end
		exp_pend = nw;
	endfunction : mset

	// chain and irq enables are set apart so that chaining without a returned code is seen too
	task automatic run_set(input int ab, input int b, input int c, input int mode, input int imode,
			input logic er);
		int n;
		n = ab ? c : b * c;
		early <= er;
		ab_sync <= ab[0];
		cnt2 <= b[15:0];
		cnt3 <= c[15:0];
		{int_ch, fin_ch} <= mode[1:0];
		{int_irq, fin_irq} <= imode[1:0];
		chain_cnt = 0;
		exp_chain = 0;
		req_ev(er ? DCC_EV_COMPLETE : DCC_EV_SUBMIT, 1'b1);
		for (int i = 0; i < n; i++) begin
			req_ev(er ? DCC_EV_SUBMIT : DCC_EV_COMPLETE, i == 0);
			if ((i == n - 1) ? mode[0] : mode[1]) exp_chain++;
			if ((i == n - 1) ? imode[0] : imode[1]) mset(code);
		end
		repeat (3) @(posedge clk);
		chk(chain_cnt, exp_chain, "chain count");
	endtask : run_set

	task automatic check_all;
		apb(1'b0, OFS_PENDING_LOW, 32'h0, exp_pend[31:0], 1'b0);
		apb(1'b0, OFS_PENDING_HIGH, 32'h0, exp_pend[63:32], 1'b0);
		for (int r = 0; r < NUM_REGIONS; r++) begin
			chk(host.irq_cnt[r], exp_irq[r], "region irq count");
		end
	endtask : check_all

	// --------------------------------
	// main sequence
	// --------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata, req_valid, req_first, early} = '0;
		{fin_ch, int_ch, fin_irq, int_irq, ab_sync, cnt2, cnt3, code} = '0;
		req_kind = DCC_EV_SUBMIT;
		req_channel = 6'h1F;
		rst = 1'b1;
		{failures, n_compared, cyc, chain_cnt, exp_chain} = '0;
		seed = 32'h528E227B;
		exp_pend = '0;
		en_m = {64{1'b1}};
		foreach (exp_irq[r]) exp_irq[r] = 0;
		foreach (mask_m[r]) mask_m[r] = '0;
		mask_m[0] = 64'h0000_0000_4000_0000;
		mask_m[1] = 64'h0000_0002_0000_0000;
		mask_m[7] = 64'h0000_0000_FFFF_FFFF;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		check_all();
		apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
		apb(1'b1, OFS_IRQ_ENABLE_LOW, 32'hFFFF_FFFF, 32'h0, 1'b0);
		apb(1'b1, OFS_IRQ_ENABLE_HIGH, 32'hFFFF_FFFF, 32'h0, 1'b0);
		apb(1'b1, 8'h40, 32'h4000_0000, 32'h0, 1'b0);
		apb(1'b1, 8'h4C, 32'h0000_0002, 32'h0, 1'b0);
		apb(1'b1, 8'h78, 32'hFFFF_FFFF, 32'h0, 1'b0);
		apb(1'b0, 8'h4C, 32'h0, 32'h0000_0002, 1'b0);
		for (int m = 1; m <= 3; m++) begin
			for (int ab = 0; ab < 2; ab++) begin
				code <= ab ? 6'd33 : 6'd30;
				run_set(ab, 4, 5, m, ab ? m : 3 - m, ab == 0);
				apb(1'b1, OFS_PENDING_CLEAR_LOW, 32'h0, 32'h0, 1'b0);
				check_all();
				apb(1'b1, OFS_PENDING_CLEAR_LOW, 32'hFFFF_FFFF, 32'h0, 1'b0);
				apb(1'b1, OFS_PENDING_CLEAR_HI, 32'hFFFF_FFFF, 32'h0, 1'b0);
				exp_pend = '0;
				check_all();
			end
		end
		// shared and arbitrary codes from random channels
		for (int i = 0; i < 8; i++) begin
			code <= 6'($random(seed));
			req_channel <= 6'($random(seed));
			run_set(0, 1, 1, 3, 3, 1'($random(seed)));
		end
		check_all();
		apb(1'b1, OFS_IRQ_REEVALUATE, 32'h1, 32'h0, 1'b0);
		for (int r = 0; r < NUM_REGIONS; r++) begin
			if ((exp_pend & en_m & mask_m[r]) != 0) exp_irq[r]++;
		end
		repeat (4) @(posedge clk);
		check_all();
		stop_test();
	end
endmodule : dma_completion_chain_irq_test
`default_nettype wire
